/* File: bench/plpm_board.sv */
// board model driving the port pins
`timescale 1ns/1ps
module plpm_board (
    input wire logic [7:0] i_lvl,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_drv,
    output logic [7:0] o_pin
);
    // driven pins follow the device, the rest follow the board
    assign o_pin = (i_oe & i_drv) | (~i_oe & i_lvl);
endmodule : plpm_board

/* File: bench/port2_low_pin_mode_config_tb.sv */
// self-checking bench for the port low pin mode block
`timescale 1ns/1ps
`include "plpm_defines.svh"
module port2_low_pin_mode_config_tb;
    import plpm_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    plpm_req_s req = '0;
    logic [7:0] lvl = 8'h00;
    logic [7:0] pov = 8'h00;
    logic [7:0] rdata, oe, po, pu, pin_in, irq, pin, v, r;
    int errors = 0;
    int n_checks = 0;
    int cnt = 0;
    int c;
    always #12.5 clk = ~clk;
    always @(posedge clk) cnt <= cnt + $countones(irq[3:0]);
    plpm_top i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_req(req), .o_rdata(rdata), .i_pin(pin),
        .i_pin_out_val(pov), .o_pin_oe(oe), .o_pin_o(po), .o_pullup_en(pu), .o_pin_in(pin_in),
        .o_edge_irq(irq));
    plpm_board i_board (.i_lvl(lvl), .i_oe(oe), .i_drv(po), .o_pin(pin));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) req <= '0;
        #1 d = rdata;
    endtask : rd
    task drive(input logic [7:0] x);
        @(posedge clk) lvl <= x;
        repeat (6) @(posedge clk);
        #1;
    endtask : drive
    function automatic int fe(int m, bit rise);
        return (m == 1) ? 4 : (m == 0) ? 4 * !rise : (m == 3) ? 4 * rise : 0;
    endfunction : fe
    task end_sim;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial
    begin
        v = 8'($urandom(32'hA8EA961D));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        pov <= 8'($urandom);
        rd(`PLPM_ADDR_LOWMODE, r);
        check("low_mode_reset", r, 8'h00);
        rd(`PLPM_ADDR_PULLUP, r);
        check("pullup_reset", r, 8'h00);
        v = 8'($urandom);
        wr(`PLPM_ADDR_LOWMODE, v);
        rd(`PLPM_ADDR_LOWMODE, r);
        check("low_mode_rw", r, v);
        v = 8'($urandom);
        wr(`PLPM_ADDR_PULLUP, v);
        rd(8'h01, r);
        check("pullup_en", pu, v);
        check("unmapped_read", r, 8'h00);
        check("pin_o", po, pov);
        wr(`PLPM_ADDR_IRQEN, 8'hFF);
        for (int m = 0; m < 4; m++)
        begin
            wr(`PLPM_ADDR_LOWMODE, {4{m[1:0]}});
            drive(8'h00);
            check("pin_oe", oe[3:0], (m == 2) ? 4'hF : 4'h0);
            check("pin_drive", pin_in[3:0], (m == 2) ? pov[3:0] : 4'h0);
            c = cnt;
            drive(8'h0F);
            check("rise_irqs", cnt - c, fe(m, 1'b1));
            c = cnt;
            drive(8'h00);
            check("fall_irqs", cnt - c, fe(m, 1'b0));
        end
        wr(`PLPM_ADDR_IRQEN, 8'h00);
        wr(`PLPM_ADDR_LOWMODE, 8'h55);
        c = cnt;
        drive(8'h0F);
        drive(8'h00);
        check("gated_irqs", cnt - c, 0);
        wr(`PLPM_ADDR_HIGHMODE, 8'hAA);
        wr(`PLPM_ADDR_CMP_INSEL, 8'hF0);
        drive(8'hFF);
        check("cmp_pin_in", pin_in, 8'h0F);
        check("high_oe", oe, 8'hF0);
        wr(`PLPM_ADDR_CMP_INSEL, 8'h00);
        drive(8'hFF);
        check("pin_in", pin_in, {pov[7:4], 4'hF});
        end_sim();
    end
endmodule : port2_low_pin_mode_config_tb

/* File: hw/plpm_defines.svh */
// constants for the port low pin mode block
`ifndef PLPM_DEFINES_SVH
`define PLPM_DEFINES_SVH
`define PLPM_ADDR_CMP_INSEL 8'hEB
`define PLPM_ADDR_PULLUP 8'hEE
`define PLPM_ADDR_IRQEN 8'hE5
`define PLPM_ADDR_LOWMODE 8'hE9
`define PLPM_ADDR_HIGHMODE 8'hEC
`define PLPM_RST_BYTE 8'h00
`define PLPM_RST_PRIME 3'h0
`define PLPM_NPINS 8
`endif

/* File: hw/plpm_pkg.sv */
// types for the port low pin mode block
package plpm_pkg;
    typedef enum logic [1:0] {
        PLPM_FALL,
        PLPM_BOTH,
        PLPM_OUT,
        PLPM_RISE
    } plpm_mode_e;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } plpm_req_s;
endpackage : plpm_pkg

/* File: hw/plpm_top.sv */
// port pin mode, pull-up, comparator select and edge request logic
`timescale 1ns/1ps
`include "plpm_defines.svh"
module plpm_top
    import plpm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire plpm_req_s i_req,
    output logic [7:0] o_rdata,
    input wire logic [7:0] i_pin,
    input wire logic [7:0] i_pin_out_val,
    output logic [7:0] o_pin_oe,
    output logic [7:0] o_pin_o,
    output logic [7:0] o_pullup_en,
    output logic [7:0] o_pin_in,
    output logic [7:0] o_edge_irq
);
    logic [7:0] low_mode_q;
    logic [7:0] high_mode_q;
    logic [7:0] pullup_q;
    logic [7:0] cmp_in_sel_q;
    logic [7:0] irqen_q;
    logic [7:0] sync1_q;
    logic [7:0] sync2_q;
    logic [7:0] prev_q;
    logic [2:0] prime_q;
    logic [15:0] modes;
    logic [7:0] irq_d;

    function automatic logic edge_hit(input logic [1:0] m, input logic cur, input logic prv);
        case (plpm_mode_e'(m))
            PLPM_FALL: edge_hit = prv & ~cur;
            PLPM_BOTH: edge_hit = prv ^ cur;
            PLPM_RISE: edge_hit = ~prv & cur;
            default: edge_hit = 1'b0;
        endcase
    endfunction : edge_hit

    assign modes = {high_mode_q, low_mode_q};

    // register writes, all reset to zero
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            low_mode_q <= `PLPM_RST_BYTE;
            high_mode_q <= `PLPM_RST_BYTE;
            pullup_q <= `PLPM_RST_BYTE;
            cmp_in_sel_q <= `PLPM_RST_BYTE;
            irqen_q <= `PLPM_RST_BYTE;
        end
        else if (i_req.wr)
        begin
            case (i_req.addr)
                `PLPM_ADDR_LOWMODE: low_mode_q <= i_req.wdata;
                `PLPM_ADDR_HIGHMODE: high_mode_q <= i_req.wdata;
                `PLPM_ADDR_PULLUP: pullup_q <= i_req.wdata;
                `PLPM_ADDR_CMP_INSEL: cmp_in_sel_q <= i_req.wdata;
                `PLPM_ADDR_IRQEN: irqen_q <= i_req.wdata;
                default: ;
            endcase
        end
    end

    // read data
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            o_rdata <= `PLPM_RST_BYTE;
        else if (i_req.rd)
        begin
            case (i_req.addr)
                `PLPM_ADDR_LOWMODE: o_rdata <= low_mode_q;
                `PLPM_ADDR_HIGHMODE: o_rdata <= high_mode_q;
                `PLPM_ADDR_PULLUP: o_rdata <= pullup_q;
                `PLPM_ADDR_CMP_INSEL: o_rdata <= cmp_in_sel_q;
                `PLPM_ADDR_IRQEN: o_rdata <= irqen_q;
                default: o_rdata <= `PLPM_RST_BYTE;
            endcase
        end
    end

    // pin synchroniser and previous sample
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            sync1_q <= `PLPM_RST_BYTE;
            sync2_q <= `PLPM_RST_BYTE;
            prev_q <= `PLPM_RST_BYTE;
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // edge detect held off until the sample pipe holds pin levels
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            prime_q <= `PLPM_RST_PRIME;
        else
            prime_q <= {prime_q[1:0], 1'h1};
    end

    // edge requests, gated by enable and comparator disconnect
    always_comb
    begin
        for (int i = 0; i < `PLPM_NPINS; i++)
        begin
            irq_d[i] = edge_hit(modes[2*i +: 2], sync2_q[i], prev_q[i]) & irqen_q[i] & prime_q[2];
            if (i >= 4 && cmp_in_sel_q[i])
                irq_d[i] = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_edge_irq <= `PLPM_RST_BYTE;
            o_pin_oe <= `PLPM_RST_BYTE;
            o_pin_o <= `PLPM_RST_BYTE;
            o_pullup_en <= `PLPM_RST_BYTE;
            o_pin_in <= `PLPM_RST_BYTE;
        end
        else
        begin
            o_edge_irq <= irq_d;
            o_pullup_en <= pullup_q;
            o_pin_o <= i_pin_out_val;
            for (int i = 0; i < `PLPM_NPINS; i++)
            begin
                o_pin_oe[i] <= (modes[2*i +: 2] == 2'h2);
                o_pin_in[i] <= (i >= 4 && cmp_in_sel_q[i]) ? 1'b0 : sync2_q[i];
            end
        end
    end

    sequence fall_seen_s;
        low_mode_q[1:0] == 2'h0 && irqen_q[0] && prev_q[0] && !sync2_q[0] && prime_q[2];
    endsequence
    sequence rise_seen_s;
        low_mode_q[1:0] == 2'h3 && irqen_q[0] && !prev_q[0] && sync2_q[0] && prime_q[2];
    endsequence
    sequence fall_quiet_s;
        low_mode_q[1:0] == 2'h3 && prev_q[0] && !sync2_q[0];
    endsequence
    sequence rise_quiet_s;
        low_mode_q[1:0] == 2'h0 && !prev_q[0] && sync2_q[0];
    endsequence

    fall_irq_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        fall_seen_s |=> o_edge_irq[0]) else $error("falling edge request missing");
    both_irq_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (low_mode_q[3:2] == 2'h1 && irqen_q[1] && prime_q[2] && (prev_q[1] != sync2_q[1])) |=> o_edge_irq[1])
        else $error("both edge request missing");
    out_noirq_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ($past(low_mode_q[5:4]) == 2'h2) |-> (!o_edge_irq[2] && o_pin_oe[2]))
        else $error("output pin wrong");
    rise_irq_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        rise_seen_s |=> o_edge_irq[0]) else $error("rising edge request missing");
    low_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req.wr && i_req.addr == `PLPM_ADDR_LOWMODE) |=> low_mode_q == $past(i_req.wdata))
        else $error("mode write lost");
    pullup_out_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req.wr && i_req.addr == `PLPM_ADDR_PULLUP) |=> ##1 o_pullup_en == $past(i_req.wdata, 2))
        else $error("pull-up not applied");
    cmp_disc_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        $past(cmp_in_sel_q[7]) |-> (!o_pin_in[7] && !o_edge_irq[7])) else $error("comparator pin not cut");
    irq_gate_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ($past(irqen_q) == 8'h00) |-> (o_edge_irq == 8'h00)) else $error("disabled request raised");
    no_edge_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (prev_q == sync2_q) |=> (o_edge_irq == 8'h00)) else $error("request without edge");

    // register and read path checks
    rd_back_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req.rd && i_req.addr == `PLPM_ADDR_LOWMODE) |=> o_rdata == $past(low_mode_q))
        else $error("mode read wrong");
    rdata_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_req.rd |=> $stable(o_rdata))
        else $error("read data moved");
    pull_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req.wr && i_req.addr == `PLPM_ADDR_PULLUP) |=> pullup_q == $past(i_req.wdata))
        else $error("pull-up write lost");
    irqen_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req.wr && i_req.addr == `PLPM_ADDR_IRQEN) |=> irqen_q == $past(i_req.wdata))
        else $error("enable write lost");
    cmp_write_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_req.wr && i_req.addr == `PLPM_ADDR_CMP_INSEL) |=> cmp_in_sel_q == $past(i_req.wdata))
        else $error("comparator select write lost");

    // pin path and drive checks
    oe_off_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ($past(low_mode_q[1:0]) != 2'h2) |-> !o_pin_oe[0])
        else $error("input pin driven");
    oe_high_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        ($past(high_mode_q[1:0]) == 2'h2) |-> o_pin_oe[4])
        else $error("upper output pin not driven");
    pin_drive_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |-> o_pin_o == $past(i_pin_out_val))
        else $error("output value not applied");
    pin_follow_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |-> o_pin_in[3:0] == $past(sync2_q[3:0]))
        else $error("lower pin input wrong");
    cmp_pass_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && !$past(cmp_in_sel_q[4])) |-> o_pin_in[4] == $past(sync2_q[4]))
        else $error("upper pin input wrong");
    sync_chain_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !$past(i_sys_rst) |-> (sync2_q == $past(sync1_q) && prev_q == $past(sync2_q)))
        else $error("sample chain broken");

    // edge hold-off and selection checks
    prime_hold_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !prime_q[2] |=> (o_edge_irq == 8'h00))
        else $error("request before sample pipe filled");
    fall_only_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        fall_quiet_s |=> !o_edge_irq[0])
        else $error("falling edge raised in rising mode");
    rise_only_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        rise_quiet_s |=> !o_edge_irq[0])
        else $error("rising edge raised in falling mode");
endmodule : plpm_top
